// File: shared/cfe_pkg.sv
// Shared constants, opcode fields and carrier types of the fetch/execute core.
package cfe_pkg;

  // ****************************************************************
  // Machine cycle timing
  // ****************************************************************
  localparam int        CFE_SLOTS      = 8;     // Clock periods per cycle.
  localparam logic [2:0] SLOT_ADDR_HI  = 3'h0;  // Upper byte goes out.
  localparam logic [2:0] SLOT_ADDR_LO  = 3'h2;  // Lower byte goes out.
  localparam logic [2:0] SLOT_RD_FIRST = 3'h3;  // First slot of data phase.
  localparam logic [2:0] SLOT_DATA     = 3'h6;  // Bus byte captured.
  localparam logic [2:0] SLOT_LAST     = 3'h7;  // Results committed.

  // ****************************************************************
  // Instruction fields: upper_code values
  // ****************************************************************
  localparam logic [3:0] UC_LDN  = 4'h0;  // Load via low_digit.
  localparam logic [3:0] UC_INC  = 4'h1;  // Increment register.
  localparam logic [3:0] UC_DEC  = 4'h2;  // Decrement register.
  localparam logic [3:0] UC_SBR  = 4'h3;  // Short branch.
  localparam logic [3:0] UC_LDA  = 4'h4;  // Load and advance.
  localparam logic [3:0] UC_STR  = 4'h5;  // Store via low_digit.
  localparam logic [3:0] UC_CTL  = 4'h7;  // Latch control group.
  localparam logic [3:0] UC_GLO  = 4'h8;  // Get low byte.
  localparam logic [3:0] UC_GHI  = 4'h9;  // Get high byte.
  localparam logic [3:0] UC_PLO  = 4'hA;  // Put low byte.
  localparam logic [3:0] UC_PHI  = 4'hB;  // Put high byte.
  localparam logic [3:0] UC_LONG = 4'hC;  // Long branch and long skip.
  localparam logic [3:0] UC_SEP  = 4'hD;  // Set counter_selector.
  localparam logic [3:0] UC_SEX  = 4'hE;  // Set data_pointer_selector.
  localparam logic [3:0] UC_ALU  = 4'hF;  // Memory and ALU group.

  // ****************************************************************
  // Instruction fields: low_digit sub-codes
  // ****************************************************************
  localparam logic [3:0] LD_ZERO = 4'h0;  // Load via data pointer.
  localparam logic [3:0] LD_ADD  = 4'h4;  // Add memory byte.
  localparam logic [3:0] LD_SD   = 4'h5;  // Memory minus accumulator.
  localparam logic [3:0] LD_SHR  = 4'h6;  // Shift right.
  localparam logic [3:0] LD_SM   = 4'h7;  // Accumulator minus memory.
  localparam logic [3:0] LD_LDI  = 4'h8;  // Load immediate.
  localparam logic [3:0] LD_REQ  = 4'hA;  // Clear output latch.
  localparam logic [3:0] LD_SEQ  = 4'hB;  // Set output latch.
  localparam logic [3:0] LD_ADI  = 4'hC;  // Add immediate.
  localparam logic [3:0] LD_SDI  = 4'hD;  // Immediate minus accumulator.
  localparam logic [3:0] LD_SHL  = 4'hE;  // Shift left.
  localparam int         LD_SKIP_BIT = 2; // Long group: set means skip.
  localparam int         LD_NEG_BIT  = 3; // Condition is inverted.

  // Condition select held in low_digit bits 1:0.
  localparam logic [1:0] CND_ALWAYS = 2'h0;
  localparam logic [1:0] CND_LATCH  = 2'h1;
  localparam logic [1:0] CND_CARRY  = 2'h2;

  // ****************************************************************
  // Reset values and types
  // ****************************************************************
  localparam logic [15:0] CFE_REG_RST = 16'h0000;
  localparam logic [3:0]  CFE_SEL_RST = 4'h0;
  localparam logic [7:0]  CFE_BYTE_RST = 8'h00;
  localparam logic [15:0] CFE_ONE = 16'h0001;

  typedef enum logic [1:0] {
    CFE_FETCH_STATE = 2'b00,  // fetch_state.
    CFE_EXEC_STATE  = 2'b01,  // execute_state.
    CFE_EXEC2_STATE = 2'b10   // Second execute of long instructions.
  } cfe_state_t;

  typedef enum logic [2:0] {
    ALU_PASS = 3'b000,
    ALU_ADD  = 3'b001,
    ALU_SD   = 3'b010,
    ALU_SM   = 3'b011,
    ALU_SHR  = 3'b100,
    ALU_SHL  = 3'b101
  } cfe_alu_op_t;

  // Outward memory port; addr and wdata come from flip-flops, the control fields are decoded.
  typedef struct packed {
    logic [7:0] addr;    // Multiplexed address lines.
    logic [7:0] wdata;   // Byte driven on the data bus.
    logic       oe_n;    // Low while the core drives the data bus.
    logic       rd;      // Memory read level.
    logic       wr;      // Memory write pulse.
    logic       hi_stb;  // Upper address byte is valid.
  } cfe_mem_t;

endpackage : cfe_pkg

// File: design/cfe_alu.sv
// Eight-bit arithmetic unit of the fetch/execute core.
module cfe_alu
  import cfe_pkg::*;
(
  input  cfe_pkg::cfe_alu_op_t op_i,     // Operation select.
  input  wire logic [7:0]      acc_i,    // Accumulator operand.
  input  wire logic [7:0]      bus_i,    // Data bus operand.
  input  wire logic            carry_i,  // Current carry_flag.
  output logic [7:0]           res_o,    // Result for accumulator.
  output logic                 carry_o   // New carry_flag.
);

  // ****************************************************************
  // Adders
  // ****************************************************************
  // Subtraction adds the inverted subtrahend plus one, so bit 8 is
  // one exactly when no borrow happened.
  wire [8:0] sum_w = {1'b0, acc_i} + {1'b0, bus_i};
  wire [8:0] sd_w  = {1'b0, bus_i} + {1'b0, ~acc_i} + 9'h001;
  wire [8:0] sm_w  = {1'b0, acc_i} + {1'b0, ~bus_i} + 9'h001;

  // Result and flag selection.
  always_comb
  begin
    res_o   = bus_i;
    carry_o = carry_i;
    case (op_i)
      ALU_PASS: res_o = bus_i;
      ALU_ADD:
      begin
        res_o   = sum_w[7:0];
        carry_o = sum_w[8];
      end
      ALU_SD:
      begin
        res_o   = sd_w[7:0];
        carry_o = sd_w[8];
      end
      ALU_SM:
      begin
        res_o   = sm_w[7:0];
        carry_o = sm_w[8];
      end
      ALU_SHR:
      begin
        res_o   = {1'b0, acc_i[7:1]};
        carry_o = acc_i[0];
      end
      ALU_SHL:
      begin
        res_o   = {acc_i[6:0], 1'b0};
        carry_o = acc_i[7];
      end
      default:
      begin
        res_o   = bus_i;
        carry_o = carry_i;
      end
    endcase
  end

endmodule : cfe_alu

// File: design/cfe_core.sv
// Register bank, sequencer and accumulator path of the 8-bit core.

module cfe_core
  import cfe_pkg::*;
(
  input  wire logic       sys_clk_i,       // 100 MHz system clock.
  input  wire logic       rst_i,           // Synchronous reset, high.
  input  wire logic [7:0] data_i,          // Data bus as seen by core.
  output cfe_pkg::cfe_mem_t mem_o,         // Memory port.
  output logic [1:0]      state_code_o,    // Current machine state.
  output logic            output_latch_o,  // Output latch level.
  output logic            carry_flag_o,    // Carry flag level.
  output logic [7:0]      acc_o            // Accumulator contents.
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] bank_q [16];
  logic [15:0] a_q;
  logic [3:0]  p_q, x_q;
  logic [3:0]  upper_q, low_q;
  logic [7:0]  acc_q, bus_q, hi_q, addr_q, wdata_q;
  logic        carry_q, latch_q, taken_q;
  logic [2:0]  slot_q;
  cfe_state_t  state_q, state_d;

  // Condition test shared by short and long control transfers.
  function automatic logic cond_met(input logic [3:0] code,
                                    input logic latch,
                                    input logic carry,
                                    input logic [7:0] acc);
    logic hit;
    case (code[1:0])
      CND_ALWAYS: hit = 1'b1;
      CND_LATCH:  hit = latch;
      CND_CARRY:  hit = carry;
      default:    hit = (acc == CFE_BYTE_RST);
    endcase
    cond_met = hit ^ code[LD_NEG_BIT];
  endfunction : cond_met

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  // The fields sit in separate registers so decode is pure wiring.
  wire is_fetch = (state_q == CFE_FETCH_STATE);
  wire is_exec  = !is_fetch;
  wire op_ldn   = (upper_q == UC_LDN) && (low_q != LD_ZERO);
  wire op_lda   = (upper_q == UC_LDA);
  wire op_str   = (upper_q == UC_STR);
  wire op_sbr   = (upper_q == UC_SBR);
  wire op_long  = (upper_q == UC_LONG);
  wire op_skip  = op_long && low_q[LD_SKIP_BIT];
  wire op_lbr   = op_long && !low_q[LD_SKIP_BIT];
  wire op_alu   = (upper_q == UC_ALU);
  wire op_imm   = op_alu && ((low_q == LD_LDI) || (low_q == LD_ADI) ||
                             (low_q == LD_SDI));
  wire op_viax  = op_alu && ((low_q == LD_ZERO) || (low_q == LD_ADD) ||
                             (low_q == LD_SD) || (low_q == LD_SM));
  wire op_shift = op_alu && ((low_q == LD_SHR) || (low_q == LD_SHL));
  wire cond_ok  = cond_met(low_q, latch_q, carry_q, acc_q);

  // Pick the selector whose register feeds the work copy.
  wire use_p    = is_fetch || op_imm || op_sbr || op_long;
  wire use_x    = is_exec && op_viax;
  wire [3:0] sel_w = use_p ? p_q : (use_x ? x_q : low_q);

  // Cycles that read or write external memory.
  wire mem_rd_cyc = is_fetch || (is_exec && (op_ldn || op_lda || op_viax
                    || op_imm || op_sbr || op_lbr));
  wire mem_wr_cyc = is_exec && op_str;

  // ****************************************************************
  // Arithmetic path
  // ****************************************************************
  // Register moves use the internal bus, memory reads the captured byte.
  wire [7:0] int_bus = (upper_q == UC_GLO) ? a_q[7:0] :
                       (upper_q == UC_GHI) ? a_q[15:8] : bus_q;
  cfe_alu_op_t alu_op;
  logic [7:0]  alu_res;
  logic        alu_c;

  assign alu_op = !op_alu ? ALU_PASS :
                  ((low_q == LD_ADD) || (low_q == LD_ADI)) ? ALU_ADD :
                  ((low_q == LD_SD) || (low_q == LD_SDI)) ? ALU_SD :
                  (low_q == LD_SM)  ? ALU_SM :
                  (low_q == LD_SHR) ? ALU_SHR :
                  (low_q == LD_SHL) ? ALU_SHL : ALU_PASS;

  cfe_alu u_alu (
    .op_i    (alu_op),
    .acc_i   (acc_q),
    .bus_i   (int_bus),
    .carry_i (carry_q),
    .res_o   (alu_res),
    .carry_o (alu_c)
  );

  wire acc_we = is_exec && (op_ldn || op_lda || op_viax || op_imm ||
                op_shift || (upper_q == UC_GLO) || (upper_q == UC_GHI));
  wire carry_we = is_exec && (alu_op != ALU_PASS);

  // ****************************************************************
  // Work copy write-back
  // ****************************************************************
  // Counting happens in the work copy so the bank needs one write port.
  wire [15:0] a_inc = a_q + CFE_ONE;
  wire [15:0] a_dec = a_q - CFE_ONE;

  // Condition is judged once, in the first execute cycle.
  wire taken_w = (state_q == CFE_EXEC_STATE) ? cond_ok : taken_q;

  logic        wb_en;
  logic [15:0] wb_val;

  always_comb
  begin
    wb_en  = 1'b0;
    wb_val = a_inc;
    if (is_fetch)
      wb_en = 1'b1;
    else
      case (upper_q)
        UC_INC, UC_LDA: wb_en = 1'b1;
        UC_DEC:
        begin
          wb_en  = 1'b1;
          wb_val = a_dec;
        end
        UC_PLO:
        begin
          wb_en  = 1'b1;
          wb_val = {a_q[15:8], acc_q};
        end
        UC_PHI:
        begin
          wb_en  = 1'b1;
          wb_val = {acc_q, a_q[7:0]};
        end
        UC_SBR:
        begin
          wb_en  = 1'b1;
          wb_val = cond_ok ? {a_q[15:8], bus_q} : a_inc;
        end
        UC_LONG:
        begin
          // A taken skip advances once per execute cycle, two bytes in all.
          wb_en  = op_lbr || taken_w;
          wb_val = (op_lbr && state_q == CFE_EXEC2_STATE && taken_q) ?
                   {hi_q, bus_q} : a_inc;
        end
        UC_ALU: wb_en = op_imm;
        default: wb_en = 1'b0;
      endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  wire last_slot = (slot_q == SLOT_LAST);

  always_comb
  begin
    case (state_q)
      CFE_FETCH_STATE: state_d = CFE_EXEC_STATE;
      CFE_EXEC_STATE:  state_d = op_long ? CFE_EXEC2_STATE :
                                 CFE_FETCH_STATE;
      CFE_EXEC2_STATE: state_d = CFE_FETCH_STATE;
      default:         state_d = CFE_FETCH_STATE;
    endcase
  end

  // Slot counter wraps every eight clocks.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      slot_q  <= SLOT_ADDR_HI;
      state_q <= CFE_FETCH_STATE;
    end
    else
    begin
      slot_q <= slot_q + 3'h1;
      if (last_slot)
        state_q <= state_d;
    end
  end

  // Address pins: work copy taken, upper byte out, then lower byte.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      a_q    <= CFE_REG_RST;
      addr_q <= CFE_BYTE_RST;
      bus_q  <= CFE_BYTE_RST;
    end
    else
    begin
      if (slot_q == SLOT_ADDR_HI)
      begin
        a_q    <= bank_q[sel_w];
        addr_q <= bank_q[sel_w][15:8];
      end
      if (slot_q == SLOT_ADDR_LO)
        addr_q <= a_q[7:0];
      if (slot_q == SLOT_DATA)
        bus_q <= data_i;
    end
  end

  // Bank write-back at the end of each machine cycle.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      for (int i = 0; i < 16; i++)
        bank_q[i] <= CFE_REG_RST;
    else if (last_slot && wb_en)
      bank_q[sel_w] <= wb_val;
  end

  // Instruction, selectors, accumulator and flags.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      upper_q <= CFE_SEL_RST;
      low_q   <= CFE_SEL_RST;
      p_q     <= CFE_SEL_RST;
      x_q     <= CFE_SEL_RST;
      acc_q   <= CFE_BYTE_RST;
      hi_q    <= CFE_BYTE_RST;
      carry_q <= 1'b0;
      latch_q <= 1'b0;
      taken_q <= 1'b0;
    end
    else if (last_slot)
    begin
      if (is_fetch)
      begin
        upper_q <= bus_q[7:4];
        low_q   <= bus_q[3:0];
      end
      if (state_q == CFE_EXEC_STATE)
      begin
        taken_q <= cond_ok;
        hi_q    <= bus_q;
      end
      if (acc_we)
        acc_q <= alu_res;
      if (carry_we)
        carry_q <= alu_c;
      if (is_exec && upper_q == UC_CTL && low_q == LD_SEQ)
        latch_q <= 1'b1;
      if (is_exec && upper_q == UC_CTL && low_q == LD_REQ)
        latch_q <= 1'b0;
      if (is_exec && upper_q == UC_SEP)
        p_q <= low_q;
      if (is_exec && upper_q == UC_SEX)
        x_q <= low_q;
    end
  end

  // Write data is held from the accumulator for the whole store cycle.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      wdata_q <= CFE_BYTE_RST;
    else if (slot_q == SLOT_ADDR_HI)
      wdata_q <= acc_q;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire data_phase = (slot_q >= SLOT_RD_FIRST);

  assign mem_o.addr   = addr_q;
  assign mem_o.wdata  = wdata_q;
  assign mem_o.oe_n   = !(mem_wr_cyc && data_phase);
  assign mem_o.rd     = mem_rd_cyc && data_phase;
  assign mem_o.wr     = mem_wr_cyc && (slot_q == SLOT_DATA);
  assign mem_o.hi_stb = (slot_q == SLOT_ADDR_LO);
  assign state_code_o = is_fetch ? CFE_FETCH_STATE : CFE_EXEC_STATE;
  assign output_latch_o = latch_q;
  assign carry_flag_o = carry_q;
  assign acc_o        = acc_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_slot_wraps: assert property (last_slot |=> slot_q == SLOT_ADDR_HI)
    else $error("slot counter did not wrap");
  a_fetch_to_exec: assert property (is_fetch && last_slot |=>
    state_q == CFE_EXEC_STATE)
    else $error("fetch not followed by execute");
  a_long_three: assert property (state_q == CFE_EXEC_STATE && op_long
    && last_slot |=> state_q == CFE_EXEC2_STATE [*8] ##1 is_fetch)
    else $error("long instruction length wrong");
  a_addr_order: assert property (slot_q == SLOT_ADDR_HI ##1 1'b1 |->
    addr_q == a_q[15:8] ##2 addr_q == a_q[7:0])
    else $error("address bytes out of order");
  a_fetch_adv: assert property (is_fetch && last_slot |=>
    bank_q[p_q] == $past(a_q) + CFE_ONE && upper_q == $past(bus_q[7:4]))
    else $error("fetch did not advance counter");
  a_glo_acc: assert property (is_exec && upper_q == UC_GLO && last_slot
    |=> acc_q == $past(a_q[7:0]) && $stable(bank_q[low_q]))
    else $error("get-low result wrong");
  a_latch_set: assert property (is_exec && upper_q == UC_CTL &&
    low_q == LD_SEQ && last_slot |=> output_latch_o)
    else $error("latch not set");
  a_sub_borrow: assert property (is_exec && op_alu && low_q == LD_SM &&
    last_slot && acc_q < bus_q |=> !carry_flag_o)
    else $error("borrow left carry set");
  a_add_carry: assert property (is_exec && op_alu && last_slot &&
    (low_q == LD_ADD || low_q == LD_ADI) |=> carry_flag_o ==
    ($past(acc_q) + $past({1'b0, bus_q}) > 9'h0FF))
    else $error("add carry wrong");

endmodule : cfe_core

// File: verification/cfe_mem_model.sv
// Behavioural external memory on the multiplexed address bus of the core.
module cfe_mem_model
  import cfe_pkg::*;
(
  input  wire logic       sys_clk_i,  // System clock.
  input  cfe_pkg::cfe_mem_t mem_i,    // Memory port of the core.
  output logic [7:0]      data_o      // Level seen on the data bus.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Storage and address latch
  // ****************************************************************
  logic [7:0]  mem [0:65535];   // Byte array, loaded by the bench.
  logic [7:0]  hi_q = 8'h00;    // Latched upper address byte.
  logic [7:0]  last_q = 8'h00;  // Previous bus level.
  wire  [15:0] full_addr = {hi_q, mem_i.addr};

  // Upper byte is caught on its strobe; stores land on the write pulse.
  // Plain always: the bench also loads the array by hierarchical writes.
  always @(posedge sys_clk_i)
  begin
    if (mem_i.hi_stb) hi_q <= mem_i.addr;
    if (mem_i.wr) mem[full_addr] <= mem_i.wdata;
    last_q <= data_o;
  end

  // An undriven bus flips every clock, so stale data never looks valid.
  // Reads never write the array, so memory stays unaltered.
  assign data_o = !mem_i.oe_n ? mem_i.wdata :
                  mem_i.rd    ? mem[full_addr] : ~last_q;
endmodule : cfe_mem_model

// File: verification/cfe_core_tb.sv
// Program-driven self-checking bench for the fetch/execute core.
module cfe_core_tb
  import cfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic       sys_clk_i = 1'b0;  // 100 MHz clock.
  logic       rst_i = 1'b1;      // Synchronous reset.
  logic [7:0] data_i;            // Bus level from the memory model.
  cfe_mem_t   mem_o;             // Memory port.
  logic [1:0] state_code_o;      // Machine state.
  logic       output_latch_o;    // Output latch.
  logic       carry_flag_o;      // Carry flag.
  logic [7:0] acc_o;             // Accumulator.
  int         n_errors = 0;
  int         n_checks = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  cfe_core cfe_core_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .data_i(data_i), .mem_o(mem_o), .state_code_o(state_code_o),
    .output_latch_o(output_latch_o), .carry_flag_o(carry_flag_o),
    .acc_o(acc_o));
  cfe_mem_model cfe_mem_model_inst (.sys_clk_i(sys_clk_i),
    .mem_i(mem_o), .data_o(data_i));

  // ****************************************************************
  // Program: immediates, stores, skip, branches, shifts, subtract
  // ****************************************************************
  // Wrong paths store 8'hEE, so any misread branch shows in memory.
  // The tail adds load-advance, add, get-high, an untaken skip, a switch
  // of program counter and a load via register.
  logic [7:0] prog [0:93] = '{
    8'hF8, 8'h00, 8'hB1, 8'hF8, 8'h80, 8'hA1, 8'hF8, 8'h3C,
    8'hFC, 8'hD0, 8'h51, 8'h11, 8'hFD, 8'h0B, 8'h51, 8'h11,
    8'h7B, 8'hC5, 8'h11, 8'h11, 8'h81, 8'h51, 8'hC2, 8'h00,
    8'h1C, 8'hC0, 8'h00, 8'h30, 8'hF8, 8'hEE, 8'h51, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hE1, 8'hF0, 8'hF6, 8'hFE, 8'h11, 8'h51, 8'h7A, 8'h39,
    8'h40, 8'hF8, 8'hEE, 8'h51, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h21, 8'hF8, 8'h05, 8'hF7, 8'h41, 8'hF4, 8'h11, 8'h51,
    8'h91, 8'hCF, 8'hF8, 8'h77, 8'h11, 8'h51, 8'hF8, 8'h58,
    8'hA2, 8'hD2, 8'hF8, 8'hEE, 8'h51, 8'h00, 8'h00, 8'h00,
    8'h21, 8'h01, 8'h11, 8'hF7, 8'h30, 8'h5C};

  // ****************************************************************
  // Compare and closing tasks
  // ****************************************************************
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // Resets the core, waits for the latch to rise, lets the program
  // settle in its closing loop and checks every result.
  task automatic run_prog();
    int i;
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    chk8("state_exec", 8'h01, {6'h00, state_code_o});
    repeat (8) @(negedge sys_clk_i);
    chk8("state_fetch", 8'h00, {6'h00, state_code_o});
    i = 0;
    while (output_latch_o !== 1'b1 && i < 400)
    begin
      @(negedge sys_clk_i);
      i++;
    end
    chk8("latch_set", 8'h01, {7'h00, output_latch_o});
    if (i >= 400) report_and_stop();
    // Whole program takes 736 clocks; the margin covers the end loop.
    repeat (700) @(negedge sys_clk_i);
    chk8("add_imm", 8'h0C, cfe_mem_model_inst.mem[16'h0080]);
    chk8("sub_imm", 8'hFF, cfe_mem_model_inst.mem[16'h0081]);
    chk8("skip_glo", 8'h82, cfe_mem_model_inst.mem[16'h0082]);
    chk8("shift_st", 8'h82, cfe_mem_model_inst.mem[16'h0083]);
    chk8("add_reg", 8'h04, cfe_mem_model_inst.mem[16'h0084]);
    chk8("skip_not", 8'h77, cfe_mem_model_inst.mem[16'h0085]);
    chk8("acc_sm", 8'h8D, acc_o);
    chk8("carry_sm", 8'h00, {7'h00, carry_flag_o});
    chk8("latch_clr", 8'h00, {7'h00, output_latch_o});
    for (i = 0; i < 94; i++)
      chk8("prog_kept", prog[i], cfe_mem_model_inst.mem[i]);
  endtask : run_prog

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // The second run starts with a reset while the core spins in its closing
  // loop to show that the sequencer and counters restart cleanly.
  initial
  begin
    for (int a = 0; a < 256; a++)
      cfe_mem_model_inst.mem[a] = (a < 94) ? prog[a] : 8'h00;
    run_prog();
    for (int a = 128; a < 134; a++)
      cfe_mem_model_inst.mem[a] = 8'h00;
    repeat (100) @(negedge sys_clk_i);
    run_prog();
    report_and_stop();
  end
endmodule : cfe_core_tb
